// *** design/can_ctl_pkg.sv ***
package can_ctl_pkg;

  // ---------------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ID_W = 29;

  // ---------------------------------------------------------------------------
  // Register offsets (byte addresses, one aligned word each)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_MASTER_CONTROL = 8'h00;
  localparam logic [7:0] OFS_MASTER_STATUS = 8'h04;
  localparam logic [7:0] OFS_TRANSMIT_STATUS = 8'h08;
  localparam logic [7:0] OFS_TRANSMIT_PRIORITY = 8'h0c;
  localparam logic [7:0] OFS_RX_FIFO_CONTROL = 8'h10;
  localparam logic [7:0] OFS_DIAGNOSIS = 8'h14;
  localparam logic [7:0] OFS_ERROR_STATUS = 8'h18;
  localparam logic [7:0] OFS_ERROR_ENABLE = 8'h1c;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_MASTER_CONTROL = 8'h02;
  localparam logic [7:0] RST_MASTER_STATUS = 8'h02;
  localparam logic [7:0] RST_TRANSMIT_STATUS = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_PRIORITY = 8'h0c;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int MC_AUTO_BUSOFF = 6;
  localparam int MC_AUTO_WAKEUP = 5;
  localparam int MC_SINGLE_SHOT = 4;
  localparam int MC_FIFO_LOCK = 3;
  localparam int MC_TX_CHRONO = 2;
  localparam int MC_SLEEP_REQ = 1;
  localparam int MC_INIT_REQ = 0;
  localparam logic [7:0] MC_WRITE_MASK = 8'h7f;
  localparam int MS_RECEIVER = 5;
  localparam int MS_TRANSMITTER = 4;
  localparam int MS_WAKEUP = 3;
  localparam int MS_ERROR_IRQ = 2;
  localparam int MS_SLEEP_ACK = 1;
  localparam int MS_INIT_ACK = 0;
  localparam int TS_OK_LSB = 4;
  localparam int TS_DONE_LSB = 0;
  localparam int TP_LOW_LSB = 5;
  localparam int TP_EMPTY_LSB = 2;
  localparam int RF_RELEASE = 5;
  localparam int RF_OVERRUN = 4;
  localparam int RF_FULL = 3;
  localparam int DG_RX = 3;
  localparam int DG_SAMPLE = 2;
  localparam int DG_SILENT = 1;
  localparam int DG_LOOPBACK = 0;
  localparam int ES_LEC_LSB = 4;
  localparam int ES_BUSOFF = 2;
  localparam int ES_PASSIVE = 1;
  localparam int ES_WARNING = 0;
  localparam logic [7:0] EE_WRITE_MASK = 8'h97;
  localparam int EE_ERROR_IRQ = 7;
  localparam int EE_LEC = 4;
  localparam int IE_WAKEUP = 7;

  // ---------------------------------------------------------------------------
  // Bus timing counts and receive FIFO depth
  // ---------------------------------------------------------------------------
  localparam logic [3:0] RECESSIVE_RUN = 4'd11;
  localparam logic [7:0] BUSOFF_RUNS = 8'd128;
  localparam logic [1:0] FIFO_DEPTH = 2'd3;

  // ---------------------------------------------------------------------------
  // Operating modes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_SLEEP,
    MODE_INIT,
    MODE_SYNC,
    MODE_NORMAL,
    MODE_BUSOFF
  } mode_t;

  // Sticky flag update: hardware set wins over clear
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    flag_next = set | (cur & ~clr);
  endfunction : flag_next

  // Register address match
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
    addr_hit = (addr == ofs);
  endfunction : addr_hit

endpackage : can_ctl_pkg

// *** design/tx_prio_if.sv ***
`timescale 1ns/1ps
interface tx_prio_if;
  logic [1:0] pending;
  logic [can_ctl_pkg::ID_W-1:0] id0;
  logic [can_ctl_pkg::ID_W-1:0] id1;
  logic chrono;
  logic newer1;
  logic nextMb;
  logic [1:0] lowest;
  logic [1:0] empty;
  logic [1:0] code;

  modport sel (input pending, input id0, input id1, input chrono, input newer1,
               output nextMb, output lowest, output empty, output code);
  modport ctl (output pending, output id0, output id1, output chrono, output newer1,
               input nextMb, input lowest, input empty, input code);
endinterface : tx_prio_if

// *** design/tx_prio_sel.sv ***
`timescale 1ns/1ps
module tx_prio_sel (
  tx_prio_if.sel pr
);
  import can_ctl_pkg::*;

  // ---------------------------------------------------------------------------
  // Mailbox ordering
  // ---------------------------------------------------------------------------
  wire bothPending = &pr.pending;
  // Ties on identifier go to mailbox 0, so the choice is always defined
  wire pickById = (pr.id1 < pr.id0);
  // Older request first when chronological order is selected
  wire pickByAge = ~pr.newer1;
  wire pickBoth = pr.chrono ? pickByAge : pickById;

  // Selection, lowest flags, empty flags and next-free code
  assign pr.nextMb = bothPending ? pickBoth : pr.pending[1];
  assign pr.lowest = bothPending ? (pr.nextMb ? 2'b01 : 2'b10) : 2'b00;
  assign pr.empty = ~pr.pending;
  assign pr.code = pr.empty[0] ? 2'd0 : (pr.empty[1] ? 2'd1 : {1'b0, ~pr.nextMb});

endmodule : tx_prio_sel

// *** design/can_mode_and_tx_status_control.sv ***
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module can_mode_and_tx_status_control (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [can_ctl_pkg::ADDR_W-1:0] paddr,
  input wire logic [can_ctl_pkg::DATA_W-1:0] pwdata,
  output logic [can_ctl_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic canRx,
  output logic canTx,
  input wire logic engTxBit,
  input wire logic bitTick,
  input wire logic rxActive,
  input wire logic txActive,
  input wire logic lastSample,
  input wire logic msgAccepted,
  output logic fifoStore,
  output logic fifoOverwrite,
  input wire logic busOffEnter,
  input wire logic errPassive,
  input wire logic errWarning,
  input wire logic lecUpdate,
  input wire logic [2:0] lecCode,
  input wire logic [1:0] txRequest,
  input wire logic [1:0] txAbort,
  input wire logic [can_ctl_pkg::ID_W-1:0] mbId0,
  input wire logic [can_ctl_pkg::ID_W-1:0] mbId1,
  output logic txStart,
  output logic txMailbox,
  input wire logic txEndOk,
  input wire logic txEndFail,
  output logic silentMode,
  output logic loopbackMode,
  output logic statusIrq
);
  import can_ctl_pkg::*;

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic [1:0] rstSync_ff;
  wire rstN = rstSync_ff[1];

  // Two-stage release; not frozen by ce so reset always completes
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rstSync_ff <= 2'b00;
    else
      rstSync_ff <= {rstSync_ff[0], 1'b1};
  end

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  wire accessPh = psel & penable;
  wire wrEn = accessPh & pwrite & ce;
  wire [7:0] wd = pwdata[7:0];
  wire hitMc = addr_hit(paddr, OFS_MASTER_CONTROL);
  wire hitMs = addr_hit(paddr, OFS_MASTER_STATUS);
  wire hitTs = addr_hit(paddr, OFS_TRANSMIT_STATUS);
  wire hitTp = addr_hit(paddr, OFS_TRANSMIT_PRIORITY);
  wire hitRf = addr_hit(paddr, OFS_RX_FIFO_CONTROL);
  wire hitDg = addr_hit(paddr, OFS_DIAGNOSIS);
  wire hitEs = addr_hit(paddr, OFS_ERROR_STATUS);
  wire hitEe = addr_hit(paddr, OFS_ERROR_ENABLE);
  wire hitIe = addr_hit(paddr, OFS_IRQ_ENABLE);
  wire mapped = hitMc | hitMs | hitTs | hitTp | hitRf | hitDg | hitEs | hitEe | hitIe;
  wire wrMc = wrEn & hitMc;
  wire wrMs = wrEn & hitMs;
  wire wrTs = wrEn & hitTs;
  wire wrRf = wrEn & hitRf;
  wire wrDg = wrEn & hitDg;
  wire wrEs = wrEn & hitEs;
  wire wrEe = wrEn & hitEe;
  wire wrIe = wrEn & hitIe;

  // A read answers only after an enabled edge took its snapshot; ce low in setup adds a wait
  logic rdHeld_ff;
  assign pready = accessPh & ce & (pwrite | rdHeld_ff);
  assign pslverr = pready & ~mapped;

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  logic [7:0] mctrl_ff;
  logic [1:0] diagCfg_ff;
  logic [7:0] errEn_ff;
  logic wkuEn_ff;
  mode_t mode_ff;
  mode_t nxt_mode;
  logic rxPrev_ff;

  wire autoBusOff = mctrl_ff[MC_AUTO_BUSOFF];
  wire autoWake = mctrl_ff[MC_AUTO_WAKEUP];
  wire singleShot = mctrl_ff[MC_SINGLE_SHOT];
  wire fifoLock = mctrl_ff[MC_FIFO_LOCK];
  wire initReq = mctrl_ff[MC_INIT_REQ];
  wire sleepReq = mctrl_ff[MC_SLEEP_REQ];

  // Start of frame while asleep is the first dominant edge on the receive pin
  wire sofSleep = (mode_ff == MODE_SLEEP) & rxPrev_ff & ~canRx;
  wire hwWake = sofSleep & autoWake;
  // Reserved bit 7 is never stored
  wire [7:0] mcWrite = wd & MC_WRITE_MASK;
  wire [7:0] nxt_mctrl = wrMc ? mcWrite :
                         (hwWake ? (mctrl_ff & ~(8'h01 << MC_SLEEP_REQ)) : mctrl_ff);

  // Master control, diagnosis and enable registers
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      mctrl_ff <= RST_MASTER_CONTROL;
      diagCfg_ff <= 2'b00;
      errEn_ff <= 8'h00;
      wkuEn_ff <= 1'b0;
      rxPrev_ff <= 1'b1;
    end
    else if (ce)
    begin
      mctrl_ff <= nxt_mctrl;
      if (wrDg)
        diagCfg_ff <= wd[1:0];
      if (wrEe)
        errEn_ff <= wd & EE_WRITE_MASK;
      if (wrIe)
        wkuEn_ff <= wd[IE_WAKEUP];
      rxPrev_ff <= canRx;
    end
  end

  assign silentMode = diagCfg_ff[DG_SILENT];
  assign loopbackMode = diagCfg_ff[DG_LOOPBACK];

  // ---------------------------------------------------------------------------
  // Recessive run counting
  // ---------------------------------------------------------------------------
  logic [3:0] recBits_ff;
  logic [7:0] recRuns_ff;
  wire counting = (mode_ff == MODE_SYNC) | (mode_ff == MODE_BUSOFF);
  wire runDone = counting & bitTick & canRx & (recBits_ff == RECESSIVE_RUN - 4'd1);
  wire busOffDone = (mode_ff == MODE_BUSOFF) & autoBusOff & runDone &
                    (recRuns_ff == BUSOFF_RUNS - 8'd1);
  wire [3:0] nxt_recBits = !counting ? 4'd0 :
                           (!bitTick ? recBits_ff :
                           ((canRx & ~runDone) ? recBits_ff + 4'd1 : 4'd0));
  wire [7:0] nxt_recRuns = (mode_ff != MODE_BUSOFF) ? 8'd0 :
                           (runDone ? recRuns_ff + 8'd1 : recRuns_ff);

  // A dominant bit restarts the current run but keeps completed runs
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      recBits_ff <= 4'd0;
      recRuns_ff <= 8'd0;
    end
    else if (ce)
    begin
      recBits_ff <= nxt_recBits;
      recRuns_ff <= nxt_recRuns;
    end
  end

  // ---------------------------------------------------------------------------
  // Mode sequencing
  // ---------------------------------------------------------------------------
  logic txBusy_ff;
  wire frameBusy = rxActive | txActive | txBusy_ff;

  // Init and sleep wait for the bus to go quiet only in normal mode; init outranks sleep except in sleep mode
  always_comb
  begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      MODE_SLEEP:
        if (!sleepReq)
          nxt_mode = initReq ? MODE_INIT : MODE_SYNC;
      MODE_INIT:
        if (!initReq)
          nxt_mode = sleepReq ? MODE_SLEEP : MODE_SYNC;
      MODE_SYNC:
        if (initReq)
          nxt_mode = MODE_INIT;
        else if (sleepReq)
          nxt_mode = MODE_SLEEP;
        else if (runDone)
          nxt_mode = MODE_NORMAL;
      MODE_NORMAL:
        if (busOffEnter)
          nxt_mode = MODE_BUSOFF;
        else if (initReq & ~frameBusy)
          nxt_mode = MODE_INIT;
        else if (sleepReq & ~frameBusy)
          nxt_mode = MODE_SLEEP;
      MODE_BUSOFF:
        if (busOffDone)
          nxt_mode = MODE_NORMAL;
        else if (initReq)
          nxt_mode = MODE_INIT;
      default:
        nxt_mode = MODE_SLEEP;
    endcase
  end

  // Sleep after reset matches the sleep request held in the control reset value
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      mode_ff <= MODE_SLEEP;
    else if (ce)
      mode_ff <= nxt_mode;
  end

  wire initAck = (mode_ff == MODE_INIT);
  wire sleepAck = (mode_ff == MODE_SLEEP);
  wire busOffFlag = (mode_ff == MODE_BUSOFF);

  // ---------------------------------------------------------------------------
  // Master status and error flags
  // ---------------------------------------------------------------------------
  logic wakeup_ff;
  logic errIrq_ff;
  logic isRx_ff;
  logic isTx_ff;
  logic [2:0] lec_ff;
  logic [2:0] errPrev_ff;
  logic statusIrq_ff;
  wire [2:0] errNow = {busOffFlag, errPassive, errWarning};
  wire [2:0] errRise = errNow & ~errPrev_ff;
  wire lecHw = lecUpdate & (lecCode != 3'd0);
  wire errEvent = (lecHw & errEn_ff[EE_LEC]) |
                  (|(errRise & errEn_ff[ES_BUSOFF:ES_WARNING]));
  wire nxt_wakeup = flag_next(wakeup_ff, sofSleep, wrMs & wd[MS_WAKEUP]);
  wire nxt_errIrq = flag_next(errIrq_ff, errEvent, wrMs & wd[MS_ERROR_IRQ]);
  wire nxt_statusIrq = (nxt_wakeup & wkuEn_ff) | (nxt_errIrq & errEn_ff[EE_ERROR_IRQ]);
  wire [2:0] nxt_lec = lecUpdate ? lecCode : (wrEs ? wd[ES_LEC_LSB+2:ES_LEC_LSB] : lec_ff);

  // Role bits follow the protocol engine with one cycle of delay
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      wakeup_ff <= 1'b0;
      errIrq_ff <= 1'b0;
      isRx_ff <= 1'b0;
      isTx_ff <= 1'b0;
      lec_ff <= 3'd0;
      errPrev_ff <= 3'd0;
      statusIrq_ff <= 1'b0;
    end
    else if (ce)
    begin
      wakeup_ff <= nxt_wakeup;
      errIrq_ff <= nxt_errIrq;
      isRx_ff <= rxActive;
      isTx_ff <= txActive;
      lec_ff <= nxt_lec;
      errPrev_ff <= errNow;
      statusIrq_ff <= nxt_statusIrq;
    end
  end

  assign statusIrq = statusIrq_ff;

  // ---------------------------------------------------------------------------
  // Receive FIFO bookkeeping
  // ---------------------------------------------------------------------------
  logic [1:0] fifoCnt_ff;
  logic fifoFull_ff;
  logic fifoOvr_ff;
  wire fifoAtTop = (fifoCnt_ff == FIFO_DEPTH);
  wire accept = msgAccepted & (mode_ff == MODE_NORMAL) & ce;
  wire release_ = wrRf & wd[RF_RELEASE] & (fifoCnt_ff != 2'd0);
  wire cntUp = accept & ~fifoAtTop;
  wire [1:0] nxt_fifoCnt = fifoCnt_ff + {1'b0, cntUp} - {1'b0, release_};
  wire nxt_fifoFull = flag_next(fifoFull_ff, cntUp & (fifoCnt_ff == FIFO_DEPTH - 2'd1),
                                release_ | (wrRf & wd[RF_FULL]));
  wire nxt_fifoOvr = flag_next(fifoOvr_ff, accept & fifoAtTop, wrRf & wd[RF_OVERRUN]);

  assign fifoStore = cntUp;
  // Locked FIFO drops the newcomer, unlocked replaces the newest slot
  assign fifoOverwrite = accept & fifoAtTop & ~fifoLock;

  // Pending count and FIFO flags
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      fifoCnt_ff <= 2'd0;
      fifoFull_ff <= 1'b0;
      fifoOvr_ff <= 1'b0;
    end
    else if (ce)
    begin
      fifoCnt_ff <= nxt_fifoCnt;
      fifoFull_ff <= nxt_fifoFull;
      fifoOvr_ff <= nxt_fifoOvr;
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit mailboxes
  // ---------------------------------------------------------------------------
  tx_prio_if pr ();
  tx_prio_sel u_sel (
    .pr (pr)
  );

  logic [1:0] pending_ff;
  logic [1:0] done_ff;
  logic [1:0] ok_ff;
  logic curMb_ff;
  logic newer1_ff;

  assign pr.pending = pending_ff;
  assign pr.id0 = mbId0;
  assign pr.id1 = mbId1;
  assign pr.chrono = mctrl_ff[MC_TX_CHRONO];
  assign pr.newer1 = newer1_ff;

  // No new frame once init or sleep is asked for
  wire startOk = (mode_ff == MODE_NORMAL) & ~txBusy_ff & ~rxActive & (|pending_ff) &
                 ~initReq & ~sleepReq & ~busOffEnter;
  assign txStart = startOk & ce;
  assign txMailbox = pr.nextMb;

  wire [1:0] curMask = curMb_ff ? 2'b10 : 2'b01;
  wire [1:0] endOkMask = (txBusy_ff & txEndOk) ? curMask : 2'b00;
  // Failure ends the request only in single-shot mode
  wire [1:0] endFailMask = (txBusy_ff & txEndFail & singleShot) ? curMask : 2'b00;
  wire [1:0] inFlight = txBusy_ff ? curMask : 2'b00;
  // Abort of the mailbox on the bus is ignored; that frame runs to its end
  wire [1:0] abortMask = txAbort & pending_ff & ~inFlight;
  wire [1:0] doneSet = endOkMask | endFailMask | abortMask;
  wire [1:0] doneClr = wrTs ? wd[TS_DONE_LSB+1:TS_DONE_LSB] : 2'b00;
  wire [1:0] nxt_pending = txRequest | (pending_ff & ~doneSet);
  wire [1:0] nxt_done = doneSet | (done_ff & ~doneClr);
  wire [1:0] nxt_ok = endOkMask | (ok_ff & ~(txRequest | doneClr));
  wire nxt_newer1 = (txRequest == 2'b10) ? 1'b1 : ((txRequest == 2'b01) ? 1'b0 : newer1_ff);
  wire nxt_txBusy = txStart | (txBusy_ff & ~(txEndOk | txEndFail));

  // Mailbox state; a failed frame stays pending for retransmission unless single-shot is set
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pending_ff <= 2'b00;
      done_ff <= 2'b00;
      ok_ff <= 2'b00;
      txBusy_ff <= 1'b0;
      curMb_ff <= 1'b0;
      newer1_ff <= 1'b0;
    end
    else if (ce)
    begin
      pending_ff <= nxt_pending;
      done_ff <= nxt_done;
      ok_ff <= nxt_ok;
      txBusy_ff <= nxt_txBusy;
      newer1_ff <= nxt_newer1;
      if (txStart)
        curMb_ff <= pr.nextMb;
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit pin
  // ---------------------------------------------------------------------------
  logic canTx_ff;

  // Recessive whenever the node must not drive the bus
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      canTx_ff <= 1'b1;
    else if (ce)
      canTx_ff <= ((mode_ff == MODE_NORMAL) & ~silentMode) ? engTxBit : 1'b1;
  end

  assign canTx = canTx_ff;

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  // Reserved bits are tied to zero in every image
  wire [7:0] msImg = {2'b00, isRx_ff, isTx_ff, wakeup_ff, errIrq_ff, sleepAck, initAck};
  wire [7:0] tsImg = {2'b00, ok_ff, 2'b00, done_ff};
  wire [7:0] tpImg = {1'b0, pr.lowest, 1'b0, pr.empty, pr.code};
  wire [7:0] rfImg = {3'b000, fifoOvr_ff, fifoFull_ff, 1'b0, fifoCnt_ff};
  wire [7:0] dgImg = {4'h0, canRx, lastSample, diagCfg_ff};
  wire [7:0] esImg = {1'b0, lec_ff, 1'b0, errNow};
  wire [7:0] ieImg = {wkuEn_ff, 7'h00};
  wire [7:0] rdMux = hitMc ? mctrl_ff :
                     hitMs ? msImg :
                     hitTs ? tsImg :
                     hitTp ? tpImg :
                     hitRf ? rfImg :
                     hitDg ? dgImg :
                     hitEs ? esImg :
                     hitEe ? errEn_ff :
                     hitIe ? ieImg : 8'h00;
  logic [7:0] rdata_ff;

  // Snapshot on the first enabled edge of a read, held until the answer
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rdata_ff <= 8'h00;
      rdHeld_ff <= 1'b0;
    end
    else if (ce)
    begin
      rdHeld_ff <= psel & ~pwrite & ~pready;
      if (psel & ~pwrite & ~rdHeld_ff)
        rdata_ff <= rdMux;
    end
  end

  assign prdata = {24'h000000, rdata_ff};

endmodule : can_mode_and_tx_status_control

// *** test/can_ctl_props.sv ***
`timescale 1ns/1ps
module can_ctl_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [can_ctl_pkg::ADDR_W-1:0] paddr,
  input wire logic [can_ctl_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic txStart
);
  import can_ctl_pkg::*;
  // -----------------------------
  // Read and frame start checks
  // -----------------------------
  // Only completed reads count; data is settled in the access cycle
  wire rd = psel && penable && pready && !pwrite;
  wire tp = rd && paddr == OFS_TRANSMIT_PRIORITY;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_HI_ZERO: assert property (rd |-> prdata[31:8] == 24'h0) else $error("high bits set");
  AST_MC_RSV: assert property (rd && paddr == OFS_MASTER_CONTROL |-> !prdata[7]) else $error("control bit7");
  AST_MS_RSV: assert property (rd && paddr == OFS_MASTER_STATUS |-> prdata[7:6] == 2'h0) else $error("status");
  AST_TS_RSV: assert property (rd && paddr == OFS_TRANSMIT_STATUS |-> !prdata[7:6] && !prdata[3:2])
    else $error("tx status");
  AST_TP_RSV: assert property (tp |-> !prdata[7] && !prdata[4] && !prdata[1]) else $error("tx prio");
  AST_LOW_ONE: assert property (tp && prdata[3:2] != 2'h0 |-> prdata[6:5] == 2'h0) else $error("low flags");
  AST_CODE_FREE: assert property (tp && (prdata[3] ^ prdata[2]) |-> prdata[0] == prdata[3]) else $error("code");
  AST_CODE_LOW: assert property (tp && prdata[3:2] == 2'h0 |-> prdata[6:5] == (prdata[0] ? 2'h2 : 2'h1))
    else $error("code low");
  // A frame start is taken once, never on two edges in a row
  AST_ONE_START: assert property (txStart |=> !txStart) else $error("double start");
  cover property (txStart);
  cover property (tp && prdata[3:2] == 2'h0);
  cover property (psel && penable && pready && paddr == OFS_MASTER_STATUS);
endmodule : can_ctl_props
bind can_mode_and_tx_status_control can_ctl_props u_can_ctl_props (.clk(clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .txStart(txStart));

// *** test/can_bus_node.sv ***
`timescale 1ns/1ps
module can_bus_node (
  input wire logic clk,
  input wire logic go,
  input wire logic canTx,
  output logic canRx,
  output logic bitTick
);
  logic [1:0] div = 2'h0;
  logic [15:0] frame = 16'hffff;
  // -----------------------------
  // Remote node
  // -----------------------------
  // Wire-and bus: a dominant bit from either side wins
  assign bitTick = div == 2'h3;
  assign canRx = frame[15] & canTx;
  always @(posedge clk)
  begin
    div <= div + 2'h1;
    if (go)
      frame <= 16'h0a5f;
    else if (bitTick)
      frame <= {frame[14:0], 1'b1};
  end
endmodule : can_bus_node

// *** test/test_can_mode_and_tx_status_control.sv ***
`timescale 1ns/1ps
module test_can_mode_and_tx_status_control;
  import can_ctl_pkg::*;
  logic clk, reset_n, psel, penable, pwrite, go, txEndOk, first, pready, pslverr, canRx, canTx, bitTick, txStart, txMb;
  logic ce, rxActive, errWarning, lecUpdate, txEndFail, stall;
  logic [2:0] lecCode;
  logic [1:0] txRequest;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [28:0] mbId0, mbId1;
  logic [15:0] seed;
  logic [32:0] rdQ[$];
  logic txQ[$];
  int n_fail, check_count, cyc;
  can_mode_and_tx_status_control u_can_mode_and_tx_status_control (.clk(clk), .reset_n(reset_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .canRx(canRx), .canTx(canTx), .engTxBit(1'b1), .bitTick(bitTick),
    .rxActive(rxActive), .txActive(1'b0), .lastSample(seed[0]), .msgAccepted(go), .fifoStore(), .fifoOverwrite(),
    .busOffEnter(1'b0), .errPassive(1'b0), .errWarning(errWarning), .lecUpdate(lecUpdate), .lecCode(lecCode),
    .txRequest(txRequest), .txAbort(2'h0), .mbId0(mbId0), .mbId1(mbId1), .txStart(txStart), .txMailbox(txMb),
    .txEndOk(txEndOk), .txEndFail(txEndFail), .silentMode(), .loopbackMode(), .statusIrq());
  can_bus_node u_can_bus_node (.clk(clk), .go(go), .canTx(canTx), .canRx(canRx), .bitTick(bitTick));
  // -----------------------------
  // Drivers and checks
  // -----------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic cmp_rd(input logic [32:0] e);
    chk("read", e, {pslverr, prdata});
  endtask : cmp_rd
  task automatic cmp_tx(input logic e);
    chk("mailbox", {32'h0, e}, {32'h0, txMb});
  endtask : cmp_tx
  task automatic stop_test(input int t);
    // Notes never taken off a queue count as misses
    n_fail += t + rdQ.size() + txQ.size();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // Request held until pready is sampled high; expectation noted first
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [8:0] e);
    if (!w)
      rdQ.push_back({e[8], 24'h0, e[7:0]});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (!pready)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic end_tx(input logic ok);
    @(posedge clk);
    txEndOk <= ok;
    txEndFail <= !ok;
    @(posedge clk);
    txEndOk <= 1'b0;
    txEndFail <= 1'b0;
  endtask : end_tx
  // Watcher; a hang ends at the cycle ceiling
  always @(posedge clk)
  begin
    cyc++;
    if (psel && penable && pready && !pwrite)
      cmp_rd(rdQ.pop_front());
    if (txStart === 1'b1)
      cmp_tx(txQ.pop_front());
    if (cyc == 20000)
      stop_test(1);
  end
  // Freeze every other cycle while stall is set, so reads meet wait states
  always @(posedge clk)
    ce <= !stall || !ce;
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    {reset_n, psel, penable, pwrite, go, txEndOk, txRequest, paddr, pwdata, mbId0, mbId1} = '0;
    {rxActive, errWarning, lecUpdate, lecCode, txEndFail, stall} = '0;
    seed = 16'd31;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(0, OFS_MASTER_CONTROL, 0, {1'b0, RST_MASTER_CONTROL});
    apb(0, OFS_MASTER_STATUS, 0, {1'b0, RST_MASTER_STATUS});
    apb(0, OFS_TRANSMIT_STATUS, 0, {1'b0, RST_TRANSMIT_STATUS});
    apb(0, OFS_TRANSMIT_PRIORITY, 0, {1'b0, RST_TRANSMIT_PRIORITY});
    apb(1, OFS_MASTER_CONTROL, 8'h22, 9'h000);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (200) @(posedge clk);
    stall <= 1'b1;
    apb(0, OFS_MASTER_CONTROL, 0, 9'h020);
    apb(0, OFS_MASTER_STATUS, 0, 9'h008);
    stall <= 1'b0;
    apb(1, OFS_MASTER_STATUS, 8'h08, 9'h000);
    apb(0, OFS_MASTER_STATUS, 0, 9'h000);
    // Software polls the receive pin before releasing the FIFO
    apb(0, OFS_DIAGNOSIS, 0, {6'h01, seed[0], 2'h0});
    apb(1, OFS_RX_FIFO_CONTROL, 8'h20, 9'h000);
    apb(0, OFS_RX_FIFO_CONTROL, 0, 9'h000);
    apb(1, OFS_ERROR_ENABLE, 8'h01, 9'h000);
    rxActive <= 1'b1;
    errWarning <= 1'b1;
    apb(0, OFS_MASTER_STATUS, 0, 9'h024);
    rxActive <= 1'b0;
    seed = lfsr(seed);
    mbId0 <= {13'h0, seed};
    seed = lfsr(seed);
    mbId1 <= {13'h0, seed};
    @(posedge clk);
    first = mbId1 < mbId0;
    txQ.push_back(first);
    txQ.push_back(first);
    txQ.push_back(!first);
    txRequest <= 2'h3;
    @(posedge clk);
    txRequest <= 2'h0;
    apb(0, OFS_TRANSMIT_PRIORITY, 0, first ? 9'h020 : 9'h041);
    end_tx(0);
    end_tx(1);
    apb(0, OFS_TRANSMIT_PRIORITY, 0, first ? 9'h009 : 9'h004);
    end_tx(1);
    apb(0, OFS_TRANSMIT_STATUS, 0, 9'h033);
    apb(1, OFS_TRANSMIT_STATUS, 8'h01, 9'h000);
    apb(0, OFS_TRANSMIT_STATUS, 0, 9'h022);
    apb(0, OFS_TRANSMIT_PRIORITY, 0, 9'h00c);
    apb(0, 8'h3c, 0, 9'h100);
    @(posedge clk);
    stop_test(0);
  end
endmodule : test_can_mode_and_tx_status_control
